// ---- hdl/fault_tolerant_bus_failure_mgr.sv ----
// digital control of a fault-tolerant low-speed bus transceiver
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ftcan_map.svh"
module fault_tolerant_bus_failure_mgr #(
  parameter logic [19:0] TXD_TO_CYC  = 20'(`TXD_TO_CYC),
  parameter logic [19:0] DOM_T_CYC   = 20'(`DOM_T_CYC),
  parameter logic [19:0] WAKE_T_CYC  = 20'(`WAKE_T_CYC),
  parameter logic [19:0] SLEEP_T_CYC = 20'(`SLEEP_T_CYC)
) (
  // clock, reset, enable
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clkEn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // protocol controller pins
  input  wire logic         txdIn,
  output logic              rxdOut,
  output logic              errOut_b,
  input  wire logic         stbIn,
  input  wire logic         enIn,
  input  wire logic         wakeIn_b,
  input  wire logic         vccLow,
  output logic              regulatorInhibitOut,
  // analog front end: comparators and receivers, dominant high
  input  wire logic         canhHighCmp,
  input  wire logic         canlHighCmp,
  input  wire logic         diffDom,
  input  wire logic         canhDom,
  input  wire logic         canlDom,
  input  wire logic         openWireSeen,
  // drivers and terminations
  output logic              canhDrive,
  output logic              canlDrive,
  output logic              highLineTermination,
  output logic              lowLineTermination,
  output logic              lowLineTermToBat,
  output ftcan_pkg::mode_t  modeOut
);
  import ftcan_pkg::*;

  localparam int SW = 11;

  // every controller and front-end pin passes two flip-flops before use
  logic [SW-1:0] syncA_q;
  logic [SW-1:0] syncB_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 11'h005; // txd and wake pins idle high, mode code 00
      syncB_q <= 11'h005;
    end else if (clkEn) begin
      syncA_q <= {openWireSeen, canlDom, canhDom, diffDom, canlHighCmp,
                  canhHighCmp, vccLow, enIn, wakeIn_b, stbIn, txdIn};
      syncB_q <= syncA_q;
    end
  end
  wire txdS     = syncB_q[0];
  wire stbS     = syncB_q[1];
  wire wakeS    = syncB_q[2];
  wire enS      = syncB_q[3];
  wire vccLowS  = syncB_q[4];
  wire canhHigh = syncB_q[5];
  wire canlHigh = syncB_q[6];
  wire diffDomS = syncB_q[7];
  wire canhDomS = syncB_q[8];
  wire canlDomS = syncB_q[9];
  wire openS    = syncB_q[10];

  // state
  mode_t        mode_q;
  mode_t        modeD;
  logic [31:0]  ctrl_q;
  logic         txdTimedOut_q;
  logic         f3Stage1_q;
  logic         f3_q;
  logic         f6_q;
  logic         f47_q;
  logic         powerOn_q;
  logic         wakeFlag_q;
  logic         wakeLevel_q;
  logic [`TMR_NUM-1:0]          tmrCond;
  logic [`TMR_NUM-1:0][19:0]    tmrLimit;
  logic [`TMR_NUM-1:0]          tmrExp;

  // fail-safe forcing of the mode inputs on a weak logic supply
  wire stbI = stbS & ~vccLowS;
  wire enI  = enS & ~vccLowS;
  wire [1:0] modeCode = {stbI, enI};
  wire isNormal = (mode_q == MODE_NORMAL);
  wire lowPower = !isNormal;
  wire txToEn   = ctrl_q[`CTRL_TXTO_EN_BIT];
  wire busWkEn  = ctrl_q[`CTRL_BUSWAKE_EN_BIT];

  // timer qualifying conditions
  wire dom47   = diffDomS & ~canhHigh & ~canlHigh;
  assign tmrCond[`TMR_TXD]     = ~txdS;
  assign tmrCond[`TMR_CANH1]   = isNormal & canhHigh & ~f3Stage1_q;
  assign tmrCond[`TMR_CANH2]   = isNormal & canhHigh & f3Stage1_q;
  assign tmrCond[`TMR_CANL]    = isNormal & canlHigh;
  assign tmrCond[`TMR_DOM]     = isNormal & dom47;
  assign tmrCond[`TMR_RECH]    = ~canhHigh & (f3Stage1_q | f3_q);
  assign tmrCond[`TMR_RECL]    = ~canlHigh & f6_q;
  assign tmrCond[`TMR_RECD]    = ~diffDomS & f47_q;
  assign tmrCond[`TMR_WAKE]    = wakeS != wakeLevel_q;
  assign tmrCond[`TMR_BUSWAKE] = lowPower & busWkEn &
                                 (diffDomS | canhDomS | canlDomS);
  assign tmrCond[`TMR_SLEEP]   = (modeCode == 2'b01) &&
                                 (mode_q != MODE_SLEEP);
  assign tmrLimit[`TMR_TXD]     = TXD_TO_CYC;
  assign tmrLimit[`TMR_CANH1]   = 20'(`CANH_T1_CYC);
  assign tmrLimit[`TMR_CANH2]   = 20'(`CANH_T2_CYC);
  assign tmrLimit[`TMR_CANL]    = 20'(`CANL_T_CYC);
  assign tmrLimit[`TMR_DOM]     = DOM_T_CYC;
  assign tmrLimit[`TMR_RECH]    = 20'(`REC_T_CYC);
  assign tmrLimit[`TMR_RECL]    = 20'(`REC_T_CYC);
  assign tmrLimit[`TMR_RECD]    = 20'(`REC_T_CYC);
  assign tmrLimit[`TMR_WAKE]    = WAKE_T_CYC;
  assign tmrLimit[`TMR_BUSWAKE] = 20'(`BUSWAKE_T_CYC);
  assign tmrLimit[`TMR_SLEEP]   = SLEEP_T_CYC;

  hold_timer #(.N(`TMR_NUM), .W(`TMR_W)) u_timers (
    .clock   (clock),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .cond    (tmrCond),
    .limit   (tmrLimit),
    .expired (tmrExp)
  );

  // wake sources: a filtered edge of either sense, a bus dominant phase
  wire wakePinEvt = tmrExp[`TMR_WAKE];
  wire wakeEvt    = wakePinEvt | tmrExp[`TMR_BUSWAKE] |
                    (stbI & (mode_q == MODE_SLEEP));

  // mode selection from the two-bit code
  always_comb begin
    modeD = mode_q;
    unique case (modeCode)
      2'b11: modeD = MODE_NORMAL;
      2'b10: modeD = MODE_POSTBY;
      2'b01: modeD = (tmrExp[`TMR_SLEEP] || mode_q == MODE_SLEEP) ?
                     MODE_SLEEP : MODE_GOSLEEP;
      2'b00: modeD = (mode_q == MODE_SLEEP) ? MODE_SLEEP : MODE_STANDBY;
    endcase
    if (modeD == MODE_SLEEP && wakeEvt) begin
      modeD = MODE_STANDBY;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_STANDBY;
    end else if (clkEn) begin
      mode_q <= modeD;
    end
  end

  // flags; a set always beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txdTimedOut_q <= 1'b0;
      powerOn_q     <= 1'b1; // reset stands for the battery power-on
      wakeFlag_q    <= 1'b0;
      wakeLevel_q   <= 1'b1;
    end else if (clkEn) begin
      if (tmrExp[`TMR_TXD] && txToEn) begin
        txdTimedOut_q <= 1'b1;
      end else if (txdS) begin
        txdTimedOut_q <= 1'b0;
      end
      if (isNormal) begin
        powerOn_q <= 1'b0;
      end
      if (wakeEvt && lowPower) begin
        wakeFlag_q <= 1'b1;
      end else if (isNormal) begin
        wakeFlag_q <= 1'b0;
      end
      if (wakePinEvt) begin
        wakeLevel_q <= wakeS;
      end
    end
  end

  // failure detector: detection only in normal mode, recovery any time
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      f3Stage1_q <= 1'b0;
      f3_q       <= 1'b0;
      f6_q       <= 1'b0;
      f47_q      <= 1'b0;
    end else if (clkEn) begin
      if (tmrExp[`TMR_CANH1]) begin
        f3Stage1_q <= 1'b1;
      end else if (tmrExp[`TMR_RECH]) begin
        f3Stage1_q <= 1'b0;
      end
      if (tmrExp[`TMR_CANH2]) begin
        f3_q <= 1'b1;
      end else if (tmrExp[`TMR_RECH]) begin
        f3_q <= 1'b0;
      end
      if (tmrExp[`TMR_CANL]) begin
        f6_q <= 1'b1;
      end else if (tmrExp[`TMR_RECL]) begin
        f6_q <= 1'b0;
      end
      if (tmrExp[`TMR_DOM]) begin
        f47_q <= 1'b1;
      end else if (tmrExp[`TMR_RECD]) begin
        f47_q <= 1'b0;
      end
    end
  end

  // path selection; open wires and shorts that need no change are
  // left alone so ongoing frames are not broken
  wire lowOff   = f6_q | f47_q;
  wire highPath = f3Stage1_q & ~f3_q | lowOff;
  wire rxDom    = f3_q ? canlDomS : (highPath ? canhDomS : diffDomS);
  wire faultAny = f3Stage1_q | f3_q | f6_q | f47_q | openS;
  wire txActive = isNormal & ~txdS & ~txdTimedOut_q;
  wire errD     = isNormal ? ~faultAny :
                  (mode_q == MODE_POSTBY ? ~powerOn_q : ~wakeFlag_q);

  // registered pin outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxdOut              <= 1'b1;
      errOut_b            <= 1'b1;
      regulatorInhibitOut <= 1'b1;
      canhDrive           <= 1'b0;
      canlDrive           <= 1'b0;
      highLineTermination <= 1'b0;
      lowLineTermination  <= 1'b0;
      lowLineTermToBat    <= 1'b0;
    end else if (clkEn) begin
      rxdOut              <= isNormal ? ~rxDom : ~wakeFlag_q;
      errOut_b            <= errD;
      regulatorInhibitOut <= (mode_q != MODE_SLEEP);
      canhDrive           <= txActive & ~f3_q;
      canlDrive           <= txActive & ~lowOff;
      highLineTermination <= f3_q;
      lowLineTermination  <= lowOff;
      lowLineTermToBat    <= lowPower;
    end
  end
  assign modeOut = mode_q;

  // apb slave, zero wait states; read data caught in the setup cycle
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hitCtrl  = (paddr == `REG_CTRL_OFS);
  wire hitStat  = (paddr == `REG_STATUS_OFS);
  wire [31:0] statusWord = {20'h0, mode_q, powerOn_q, wakeFlag_q,
                            txdTimedOut_q, f47_q, f6_q, f3_q, f3Stage1_q};
  wire [31:0] rdMux = hitCtrl ? ctrl_q : (hitStat ? statusWord : 32'h0);
  assign pready  = 1'b1;
  assign pslverr = access & ~(hitCtrl | (hitStat & ~pwrite));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RESET;
      prdata <= 32'h0;
    end else if (clkEn) begin
      if (access && pwrite && hitCtrl) begin
        ctrl_q <= {30'h0, pwdata[1:0]};
      end
      if (setup) begin
        prdata <= rdMux;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence stageOneSeen;
    f3Stage1_q;
  endsequence
  sequence wireSwitch;
    $rose(f3_q);
  endsequence

  txd_block_a: assert property (clkEn && txdTimedOut_q |=>
    !canhDrive && !canlDrive)
    else $error("drivers active after dominant time-out");
  txd_restart_a: assert property (clkEn && txdS |=> !txdTimedOut_q)
    else $error("time-out not cleared by high transmit input");
  rxd_diff_a: assert property (clkEn && isNormal && !f3Stage1_q &&
    !f3_q && !lowOff |=> rxdOut == !$past(diffDomS))
    else $error("receive output not differential");
  two_step_a: assert property (wireSwitch |-> $past(f3Stage1_q))
    else $error("low-line mode without first step");
  high_off_a: assert property (clkEn && f3_q ##0 stageOneSeen |=>
    !canhDrive && highLineTermination)
    else $error("high driver not off in low-line mode");
  low_off_a: assert property (clkEn && lowOff |=>
    !canlDrive && lowLineTermination)
    else $error("low driver not off on low-line failure");
  err_fault_a: assert property (clkEn && isNormal && faultAny |=>
    !errOut_b)
    else $error("fault output not low on failure");
  inh_sleep_a: assert property (clkEn && mode_q == MODE_SLEEP |=>
    !regulatorInhibitOut)
    else $error("inhibit output high in sleep");
  po_clear_a: assert property (clkEn && isNormal |=> !powerOn_q)
    else $error("power-on flag kept in normal mode");
  fail_safe_a: assert property (clkEn && vccLowS |=>
    mode_q != MODE_NORMAL && mode_q != MODE_POSTBY)
    else $error("weak supply did not force the mode inputs low");
endmodule

// ---- hdl/ftcan_map.svh ----
// offsets, field positions, reset values and timing counts of the manager
`ifndef FTCAN_MAP_SVH
`define FTCAN_MAP_SVH

// register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_STATUS_OFS      8'h04
// control fields
`define CTRL_TXTO_EN_BIT    0
`define CTRL_BUSWAKE_EN_BIT 1
`define CTRL_RESET          32'h0000_0003

// time base
`define CLK_MHZ             200
`define TXD_TO_US           1000
`define CANH_T1_US          10
`define CANH_T2_US          20
`define CANL_T_US           10
`define DOM_T_US            200
`define REC_T_US            15
`define BUSWAKE_T_US        20
`define WAKE_T_US           40
`define SLEEP_T_US          50
`define TXD_TO_CYC          (`TXD_TO_US * `CLK_MHZ)
`define CANH_T1_CYC         (`CANH_T1_US * `CLK_MHZ)
`define CANH_T2_CYC         (`CANH_T2_US * `CLK_MHZ)
`define CANL_T_CYC          (`CANL_T_US * `CLK_MHZ)
`define DOM_T_CYC           (`DOM_T_US * `CLK_MHZ)
`define REC_T_CYC           (`REC_T_US * `CLK_MHZ)
`define BUSWAKE_T_CYC       (`BUSWAKE_T_US * `CLK_MHZ)
`define WAKE_T_CYC          (`WAKE_T_US * `CLK_MHZ)
`define SLEEP_T_CYC         (`SLEEP_T_US * `CLK_MHZ)

// timer channels
`define TMR_NUM             11
`define TMR_W               20
`define TMR_TXD             0
`define TMR_CANH1           1
`define TMR_CANH2           2
`define TMR_CANL            3
`define TMR_DOM             4
`define TMR_RECH            5
`define TMR_RECL            6
`define TMR_RECD            7
`define TMR_WAKE            8
`define TMR_BUSWAKE         9
`define TMR_SLEEP           10

`endif

// ---- hdl/ftcan_pkg.sv ----
// types shared by the bus failure manager
package ftcan_pkg;
  typedef enum logic [4:0] {
    MODE_NORMAL  = 5'h01,
    MODE_STANDBY = 5'h02,
    MODE_POSTBY  = 5'h04,
    MODE_GOSLEEP = 5'h08,
    MODE_SLEEP   = 5'h10
  } mode_t;
endpackage

// ---- hdl/hold_timer.sv ----
// bank of restartable hold timers, one per qualifying condition
`timescale 1ns/10ps
module hold_timer #(
  parameter int N = 1,
  parameter int W = 20
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                clkEn,
  // conditions and limits
  input  wire logic [N-1:0]        cond,
  input  wire logic [N-1:0][W-1:0] limit,
  // condition held for its full limit
  output logic      [N-1:0]        expired
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_tmr
      logic [W-1:0] cnt_q;
      // restart on lapse, saturate at the limit so expiry stays a level
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          cnt_q <= '0;
        end else if (clkEn) begin
          if (!cond[i]) begin
            cnt_q <= '0;
          end else if (cnt_q != limit[i]) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
      assign expired[i] = cond[i] && (cnt_q == limit[i]);

      restart_a: assert property (@(posedge clock) disable iff (!rst_b)
        clkEn && !cond[i] |=> cnt_q == '0)
        else $error("hold timer did not restart");
      bound_a: assert property (@(posedge clock) disable iff (!rst_b)
        cnt_q <= limit[i] || $changed(limit[i]))
        else $error("hold timer ran past its limit");
    end
  endgenerate
endmodule

// ---- tb/can_ctrl_model.sv ----
// protocol controller model: drives transmit data and the mode pins
`timescale 1ns/10ps
module can_ctrl_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // commands from the bench
  input  wire logic [1:0] modeCode,
  input  wire logic       txdBit,
  // pins toward the transceiver
  output logic            txdIn,
  output logic            stbIn,
  output logic            enIn
);
  // pins move just after an edge; recessive and standby during reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txdIn <= 1'b1;
      {stbIn, enIn} <= 2'b00;
    end else begin
      txdIn <= txdBit;
      {stbIn, enIn} <= modeCode;
    end
  end
endmodule

// ---- tb/fault_tolerant_bus_failure_mgr_test.sv ----
// self-checking bench for the bus failure manager
`timescale 1ns/10ps
module fault_tolerant_bus_failure_mgr_test;
  import ftcan_pkg::*;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rxdOut, errOut_b, txdIn, stbIn, enIn, wakeIn_b, vccLow;
  logic        canhHighCmp, canlHighCmp, diffDom, canhDom, canlDom, termBat;
  logic        openWire, canhDrive, canlDrive, termH, termL, txdBit, regulator_inhibit_out;
  logic [1:0]  modeCode;
  mode_t       modeOut;
  int          failCount = 0;
  int          checked = 0;

  // short counts keep the run brief; fixed detector counts stay as built
  fault_tolerant_bus_failure_mgr #(.TXD_TO_CYC(20'h14), .DOM_T_CYC(20'h14),
    .WAKE_T_CYC(20'h14), .SLEEP_T_CYC(20'h14)) DUT (
    .clock(clock), .rst_b(rst_b), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txdIn(txdIn),
    .rxdOut(rxdOut), .errOut_b(errOut_b), .stbIn(stbIn), .enIn(enIn),
    .wakeIn_b(wakeIn_b), .vccLow(vccLow), .regulatorInhibitOut(regulator_inhibit_out),
    .canhHighCmp(canhHighCmp), .canlHighCmp(canlHighCmp),
    .diffDom(diffDom), .canhDom(canhDom), .canlDom(canlDom),
    .openWireSeen(openWire), .canhDrive(canhDrive), .canlDrive(canlDrive),
    .highLineTermination(termH), .lowLineTermination(termL),
    .lowLineTermToBat(termBat), .modeOut(modeOut));

  // local protocol controller
  can_ctrl_model ctrl (.clock(clock), .rst_b(rst_b), .modeCode(modeCode),
    .txdBit(txdBit), .txdIn(txdIn), .stbIn(stbIn), .enIn(enIn));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      failCount++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // samples land 1 ns after the edge so that edge's updates have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    if (pready !== 1'b1) begin
      check("pready", 32'(pready), 32'h1);
      tallyAndFinish();
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return errOut_b;
      1: return termH;
      2: return termL;
      3: return regulator_inhibit_out;
      default: return canhDrive;
    endcase
  endfunction

  // bounded wait for one output to reach a level
  task automatic waitSig(input int w, input logic v, input int n);
    int i;
    i = 0;
    checked++;
    while (pick(w) !== v) begin
      if (i == n) begin
        check($sformatf("wait%0d", w), 32'(pick(w)), 32'(v));
        tallyAndFinish();
      end
      tick(1);
      i++;
    end
  endtask

  task automatic setMode(input logic [1:0] c);
    @(posedge clock) modeCode <= c;
    tick(8);
  endtask

  // short dominant bit, then compare which drivers came on
  task automatic txCheck(input logic h, input logic l);
    @(posedge clock) txdBit <= 1'b0;
    tick(5);
    check("canhDrive", 32'(canhDrive), 32'(h));
    check("canlDrive", 32'(canlDrive), 32'(l));
    @(posedge clock) txdBit <= 1'b1;
    tick(5);
  endtask

  task automatic testReset;
    check("inhibit", 32'(regulator_inhibit_out), 32'h1);
    check("termToBat", 32'(termBat), 32'h1);
    check("mode", 32'(modeOut), 32'(MODE_STANDBY));
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    check("powerOn", 32'(rd[6]), 32'h1);
    setMode(2'b10);
    check("mode", 32'(modeOut), 32'(MODE_POSTBY));
    check("errOut_b", 32'(errOut_b), 32'h0);
    $display("done reset");
  endtask

  task automatic testNormal;
    setMode(2'b11);
    check("mode", 32'(modeOut), 32'(MODE_NORMAL));
    check("termToBat", 32'(termBat), 32'h0);
    check("errOut_b", 32'(errOut_b), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    check("powerOn", 32'(rd[6]), 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    check("roWrite", 32'(err), 32'h1);
    @(posedge clock) diffDom <= 1'b1;
    tick(5);
    check("rxdOut", 32'(rxdOut), 32'h0);
    @(posedge clock) diffDom <= 1'b0;
    tick(5);
    check("rxdOut", 32'(rxdOut), 32'h1);
    $display("done normal");
  endtask

  task automatic testTxTimeout;
    repeat (3) begin
      @(posedge clock) txdBit <= 1'b0;
      tick(15);
      check("canhDrive", 32'(canhDrive), 32'h1);
      @(posedge clock) txdBit <= 1'b1;
      tick(3);
    end
    @(posedge clock) txdBit <= 1'b0;
    tick(15);
    check("canhDrive", 32'(canhDrive), 32'h1);
    waitSig(4, 1'b0, 20);
    apb(1'b0, 8'h04, 32'h0);
    check("timedOut", 32'(rd[4]), 32'h1);
    @(posedge clock) txdBit <= 1'b1;
    tick(6);
    apb(1'b0, 8'h04, 32'h0);
    check("timedOut", 32'(rd[4]), 32'h0);
    $display("done txTimeout");
  endtask

  task automatic testFailures;
    @(posedge clock) canhHighCmp <= 1'b1;
    tick(1900);
    check("errOut_b", 32'(errOut_b), 32'h1);
    waitSig(0, 1'b0, 200);
    // single-wire reception through the high line only
    @(posedge clock) canhDom <= 1'b1;
    tick(5);
    check("rxdOut", 32'(rxdOut), 32'h0);
    @(posedge clock) canhDom <= 1'b0;
    waitSig(1, 1'b1, 4100);
    // low-line mode receives through the low line only
    @(posedge clock) canlDom <= 1'b1;
    tick(5);
    check("rxdOut", 32'(rxdOut), 32'h0);
    @(posedge clock) canlDom <= 1'b0;
    txCheck(1'b0, 1'b1);
    @(posedge clock) canhHighCmp <= 1'b0;
    waitSig(0, 1'b1, 3100);
    check("termH", 32'(termH), 32'h0);
    @(posedge clock) canlHighCmp <= 1'b1;
    waitSig(2, 1'b1, 2100);
    check("errOut_b", 32'(errOut_b), 32'h0);
    txCheck(1'b1, 1'b0);
    @(posedge clock) canlHighCmp <= 1'b0;
    waitSig(2, 1'b0, 3100);
    @(posedge clock) diffDom <= 1'b1;
    tick(5);
    check("rxdOut", 32'(rxdOut), 32'h0);
    waitSig(2, 1'b1, 60);
    check("termH", 32'(termH), 32'h0);
    txCheck(1'b1, 1'b0);
    @(posedge clock) diffDom <= 1'b0;
    tick(2000);
    check("termL", 32'(termL), 32'h1);
    waitSig(2, 1'b0, 1200);
    waitSig(0, 1'b1, 20);
    $display("done failures");
  endtask

  task automatic testOpenWire;
    @(posedge clock) openWire <= 1'b1;
    tick(6);
    check("errOut_b", 32'(errOut_b), 32'h0);
    check("terms", 32'({termH, termL}), 32'h0);
    txCheck(1'b1, 1'b1);
    @(posedge clock) openWire <= 1'b0;
    tick(6);
    check("errOut_b", 32'(errOut_b), 32'h1);
    $display("done openWire");
  endtask

  // falling then rising wake edge, each from sleep
  task automatic testSleepWake;
    repeat (2) begin
      setMode(2'b01);
      waitSig(3, 1'b0, 60);
      check("mode", 32'(modeOut), 32'(MODE_SLEEP));
      setMode(2'b00);
      @(posedge clock) wakeIn_b <= ~wakeIn_b;
      waitSig(3, 1'b1, 60);
      check("mode", 32'(modeOut), 32'(MODE_STANDBY));
      check("errOut_b", 32'(errOut_b), 32'h0);
      check("rxdOut", 32'(rxdOut), 32'h0);
    end
    setMode(2'b11);
    check("errOut_b", 32'(errOut_b), 32'h1);
    $display("done sleepWake");
  endtask

  task automatic testVccLow;
    @(posedge clock) vccLow <= 1'b1;
    tick(8);
    check("mode", 32'(modeOut), 32'(MODE_STANDBY));
    @(posedge clock) vccLow <= 1'b0;
    tick(8);
    check("mode", 32'(modeOut), 32'(MODE_NORMAL));
    $display("done vccLow");
  endtask

  // inputs at time zero, reset for five cycles, then the scenarios
  initial begin
    {psel, penable, pwrite, canhHighCmp, canlHighCmp} = 5'h0;
    {diffDom, canhDom, canlDom, openWire, vccLow} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    modeCode = 2'b00;
    txdBit = 1'b1;
    wakeIn_b = 1'b1;
    rst_b = 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    tick(1);
    testReset();
    testNormal();
    testTxTimeout();
    testFailures();
    testOpenWire();
    testSleepWake();
    testVccLow();
    tallyAndFinish();
  end
endmodule
